// >>> hw/sct_top.sv
// cadence timer register file, apb slave and oscillator engines
`timescale 1ns/1ps
`include "sct_defines.svh"

// ------------------------------------------------------------------
// block overview
// ------------------------------------------------------------------
// three cadence engines (tone 2, pulse meter, ringing) share one
// timebase; software programs 16-bit on and off counts as byte pairs.
// registers sit on apb, one byte per aligned 32-bit word.

// Operation
// R1: tone1 off count high byte is writable
// R2: tone2 on period, 16-bit, 125 us units
// R3: tone2 off period, 16-bit, 125 us units
// R4: meter on period, 16-bit, 125 us units
// R5: meter off period, 16-bit, 125 us units
// R6: ring burst, 16-bit count, 125 us units
// R7: ring silence, 16-bit count, 125 us units
// R8: timer and caller-id bytes reset to zero
// R9: caller-id bit taken when enable and reload
// R10: timer enables bound active and silent periods
// R11: zero-cross option delays stop to crossing
// R12: status bit shows active phase per oscillator
// R13: periods alternate, counts reloaded each period
// R14: 125 us tick decrements running count
module sct_top #(
    parameter int ADDR_W      = 12,
    parameter int TICK_CYCLES = `SCT_TICK_CYCLES
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              tone2ZeroCross,
    output logic                   tone2Active,
    output logic                   meterActive,
    output logic                   ringActive,
    output logic      [15:0]       tone1OffCount,
    output logic                   callerIdBitOut
);
    import sct_pkg::*;

    // ------------------------------------------------------------------
    // constants and helpers
    // ------------------------------------------------------------------
    localparam int NUM_TIMER_BYTES = 14;
    localparam int NUM_OSC         = 3;
    localparam int OSC_TONE2       = 0;
    localparam int OSC_METER       = 1;
    localparam int OSC_RING        = 2;

    // a word-aligned access inside the low page, as register index
    function automatic logic [6:0] indexOf(input logic [ADDR_W-1:0] a);
        indexOf = a[8:2];
    endfunction : indexOf

    function automatic logic aligned(input logic [ADDR_W-1:0] a);
        aligned = (a[1:0] == 2'b00) && (a[ADDR_W-1:9] == '0);
    endfunction : aligned

    // true for the block of plain timer bytes
    function automatic logic isTimerIdx(input logic [6:0] idx);
        isTimerIdx = (idx >= `SCT_IDX_TIMER_FIRST) &&
                     (idx <= `SCT_IDX_TIMER_LAST);
    endfunction : isTimerIdx

    function automatic logic [3:0] timerSlot(input logic [6:0] idx);
        logic [6:0] diff;
        diff      = idx - `SCT_IDX_TIMER_FIRST;
        timerSlot = diff[3:0];
    endfunction : timerSlot

    // every index that answers without an error
    function automatic logic isMapped(input logic [6:0] idx);
        isMapped = isTimerIdx(idx)                 ||
                   (idx == `SCT_IDX_OSC1_CTL)      ||
                   (idx == `SCT_IDX_TONE2_CTL)     ||
                   (idx == `SCT_IDX_RING_CTL)      ||
                   (idx == `SCT_IDX_METER_CTL)     ||
                   (idx == `SCT_IDX_CID_BUF)       ||
                   (idx == `SCT_IDX_CID_CTL);
    endfunction : isMapped

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [7:0] timerByte [NUM_TIMER_BYTES];
    logic       oscillatorReload;
    logic       tone2OscEnable;
    logic       tone2OnTimerEnable;
    logic       tone2OffTimerEnable;
    logic       tone2ZeroCrossStop;
    logic       ringOscEnable;
    logic       ringOnTimerEnable;
    logic       ringOffTimerEnable;
    logic       meterOscEnable;
    logic       meterOnTimerEnable;
    logic       meterOffTimerEnable;
    logic       callerIdGenEnable;
    logic       callerIdNextBit;

    logic [6:0] reqIdx;
    logic       reqOk;
    logic       setupPhase;
    logic       writeCommit;
    logic       byteWrite;
    logic [7:0] wrByte;
    logic [7:0] next_readByte;
    logic       tick;
    logic       oscActive [NUM_OSC];
    logic       oscZeroCross [NUM_OSC];
    sct_cfg_t   oscCfg [NUM_OSC];

    logic [15:0] tone2OnCount;
    logic [15:0] tone2OffCount;
    logic [15:0] meterOnCount;
    logic [15:0] meterOffCount;
    logic [15:0] ringOnCount;
    logic [15:0] ringOffCount;

    // ------------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------------
    assign reqIdx     = indexOf(paddr);
    assign reqOk      = aligned(paddr) && isMapped(reqIdx);
    assign setupPhase = psel && !penable;
    // a write lands only at the edge that completes the access
    assign writeCommit = psel && penable && pready && pwrite && reqOk;
    // registers are a byte wide, so only lane 0 matters
    assign byteWrite  = writeCommit && pstrb[0];
    assign wrByte     = pwdata[7:0];

    // ready one cycle after setup, so every access has no wait state
    always_ff @(posedge clock)
    begin
        if (!nrst)
            pready <= 1'b0;
        else
            pready <= setupPhase;
    end

    // error flag for unaligned or unmapped addresses, set at setup
    always_ff @(posedge clock)
    begin
        // follows ready, so it never outlasts the access cycle
        if (!nrst)
            pslverr <= 1'b0;
        else
            pslverr <= setupPhase && !reqOk;
    end

    // read data captured at setup, held through the access phase
    always_ff @(posedge clock)
    begin
        if (!nrst)
            prdata <= 32'h0000_0000;
        else if (setupPhase && !pwrite)
            prdata <= {24'h00_0000, next_readByte};
    end

    // ------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------
    // reserved and out-of-scope bits read as zero
    always_comb
    begin
        next_readByte = `SCT_RESET_BYTE;
        if (!reqOk)
            next_readByte = `SCT_RESET_BYTE;
        else if (isTimerIdx(reqIdx))
            next_readByte = timerByte[timerSlot(reqIdx)]; // R8
        else
        begin
            case (reqIdx)
                `SCT_IDX_OSC1_CTL:
                    next_readByte[`SCT_BIT_RELOAD] = oscillatorReload;
                `SCT_IDX_TONE2_CTL:
                begin
                    next_readByte[`SCT_BIT_STATUS]     = tone2Active; // R12
                    next_readByte[`SCT_BIT_ZERO_CROSS] = tone2ZeroCrossStop;
                    next_readByte[`SCT_BIT_ON_EN]      = tone2OnTimerEnable;
                    next_readByte[`SCT_BIT_OFF_EN]     = tone2OffTimerEnable;
                    next_readByte[`SCT_BIT_OSC_EN]     = tone2OscEnable;
                end
                `SCT_IDX_RING_CTL:
                begin
                    next_readByte[`SCT_BIT_STATUS] = ringActive; // R12
                    next_readByte[`SCT_BIT_ON_EN]  = ringOnTimerEnable;
                    next_readByte[`SCT_BIT_OFF_EN] = ringOffTimerEnable;
                    next_readByte[`SCT_BIT_OSC_EN] = ringOscEnable;
                end
                `SCT_IDX_METER_CTL:
                begin
                    next_readByte[`SCT_BIT_STATUS] = meterActive; // R12
                    next_readByte[`SCT_BIT_ON_EN]  = meterOnTimerEnable;
                    next_readByte[`SCT_BIT_OFF_EN] = meterOffTimerEnable;
                    next_readByte[`SCT_BIT_OSC_EN] = meterOscEnable;
                end
                `SCT_IDX_CID_BUF:
                    next_readByte[`SCT_BIT_CID_DATA] = callerIdNextBit; // R9
                `SCT_IDX_CID_CTL:
                    next_readByte[`SCT_BIT_CID_EN] = callerIdGenEnable;
                default:
                    next_readByte = `SCT_RESET_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // timer byte storage
    // ------------------------------------------------------------------
    // each byte pair is independent; software writes low then high
    generate
        for (genvar i = 0; i < NUM_TIMER_BYTES; i++)
        begin : g_timer_byte
            always_ff @(posedge clock)
            begin
                if (!nrst)
                    timerByte[i] <= `SCT_RESET_BYTE; // R8
                else if (byteWrite && isTimerIdx(reqIdx) &&
                         timerSlot(reqIdx) == 4'(i))
                    timerByte[i] <= wrByte; // R8
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // control bytes
    // ------------------------------------------------------------------
    // tone 2 control; status bit is read only
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            tone2ZeroCrossStop  <= 1'b0;
            tone2OnTimerEnable  <= 1'b0;
            tone2OffTimerEnable <= 1'b0;
            tone2OscEnable      <= 1'b0;
        end
        else if (byteWrite && reqIdx == `SCT_IDX_TONE2_CTL)
        begin
            tone2ZeroCrossStop  <= wrByte[`SCT_BIT_ZERO_CROSS]; // R11
            tone2OnTimerEnable  <= wrByte[`SCT_BIT_ON_EN];
            tone2OffTimerEnable <= wrByte[`SCT_BIT_OFF_EN];
            tone2OscEnable      <= wrByte[`SCT_BIT_OSC_EN];
        end
    end

    // ringing control
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            ringOnTimerEnable  <= 1'b0;
            ringOffTimerEnable <= 1'b0;
            ringOscEnable      <= 1'b0;
        end
        else if (byteWrite && reqIdx == `SCT_IDX_RING_CTL)
        begin
            ringOnTimerEnable  <= wrByte[`SCT_BIT_ON_EN];
            ringOffTimerEnable <= wrByte[`SCT_BIT_OFF_EN];
            ringOscEnable      <= wrByte[`SCT_BIT_OSC_EN];
        end
    end

    // pulse meter control
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            meterOnTimerEnable  <= 1'b0;
            meterOffTimerEnable <= 1'b0;
            meterOscEnable      <= 1'b0;
        end
        else if (byteWrite && reqIdx == `SCT_IDX_METER_CTL)
        begin
            meterOnTimerEnable  <= wrByte[`SCT_BIT_ON_EN];
            meterOffTimerEnable <= wrByte[`SCT_BIT_OFF_EN];
            meterOscEnable      <= wrByte[`SCT_BIT_OSC_EN];
        end
    end

    // reload bit and caller-id enable live in separate bytes
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            oscillatorReload  <= 1'b0;
            callerIdGenEnable <= 1'b0;
        end
        else if (byteWrite && reqIdx == `SCT_IDX_OSC1_CTL)
            oscillatorReload <= wrByte[`SCT_BIT_RELOAD];
        else if (byteWrite && reqIdx == `SCT_IDX_CID_CTL)
            callerIdGenEnable <= wrByte[`SCT_BIT_CID_EN];
    end

    // ------------------------------------------------------------------
    // caller-id bit buffer
    // ------------------------------------------------------------------
    // only bit 0 is stored; upper bits always read zero
    always_ff @(posedge clock)
    begin
        if (!nrst)
            callerIdNextBit <= 1'b0; // R8
        else if (byteWrite && reqIdx == `SCT_IDX_CID_BUF)
            callerIdNextBit <= wrByte[`SCT_BIT_CID_DATA]; // R9
    end

    // generator takes the buffered bit only while both gates are on
    always_ff @(posedge clock)
    begin
        if (!nrst)
            callerIdBitOut <= 1'b0;
        else if (callerIdGenEnable && oscillatorReload)
            callerIdBitOut <= callerIdNextBit; // R9
    end

    // ------------------------------------------------------------------
    // count assembly from byte pairs
    // ------------------------------------------------------------------
    // counts are live: a write mid-period takes effect at next reload
    always_ff @(posedge clock)
    begin
        if (!nrst)
            tone1OffCount <= 16'h0000;
        else
            tone1OffCount <= {timerByte[1], timerByte[0]}; // R1
    end

    assign tone2OnCount  = {timerByte[3], timerByte[2]};   // R2
    assign tone2OffCount = {timerByte[5], timerByte[4]};   // R3
    assign meterOnCount  = {timerByte[7], timerByte[6]};   // R4
    assign meterOffCount = {timerByte[9], timerByte[8]};   // R5
    assign ringOnCount   = {timerByte[11], timerByte[10]}; // R6
    assign ringOffCount  = {timerByte[13], timerByte[12]}; // R7

    // ------------------------------------------------------------------
    // engine settings
    // ------------------------------------------------------------------
    // only tone 2 offers the zero-cross stop; the others stop at once
    always_comb
    begin
        oscCfg[OSC_TONE2] = '{
            oscEnable:      tone2OscEnable,
            onTimerEnable:  tone2OnTimerEnable,
            offTimerEnable: tone2OffTimerEnable,
            zeroCrossStop:  tone2ZeroCrossStop,
            onCount:        tone2OnCount,
            offCount:       tone2OffCount};
        oscCfg[OSC_METER] = '{
            oscEnable:      meterOscEnable,
            onTimerEnable:  meterOnTimerEnable,
            offTimerEnable: meterOffTimerEnable,
            zeroCrossStop:  1'b0,
            onCount:        meterOnCount,
            offCount:       meterOffCount};
        oscCfg[OSC_RING] = '{
            oscEnable:      ringOscEnable,
            onTimerEnable:  ringOnTimerEnable,
            offTimerEnable: ringOffTimerEnable,
            zeroCrossStop:  1'b0,
            onCount:        ringOnCount,
            offCount:       ringOffCount};
        oscZeroCross[OSC_TONE2] = tone2ZeroCross;
        oscZeroCross[OSC_METER] = 1'b0;
        oscZeroCross[OSC_RING]  = 1'b0;
    end

    // ------------------------------------------------------------------
    // timebase and cadence engines
    // ------------------------------------------------------------------
    sct_tick_gen #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock (clock),
        .nrst  (nrst),
        .tick  (tick)
    );

    generate
        for (genvar k = 0; k < NUM_OSC; k++)
        begin : g_osc
            sct_cadence u_cadence (
                .clock     (clock),
                .nrst      (nrst),
                .tick      (tick),
                .zeroCross (oscZeroCross[k]),
                .cfg       (oscCfg[k]),
                .active    (oscActive[k])
            );
        end
    endgenerate

    // active flags come straight from each engine's flip-flop
    assign tone2Active = oscActive[OSC_TONE2]; // R12
    assign meterActive = oscActive[OSC_METER]; // R12
    assign ringActive  = oscActive[OSC_RING];  // R12

endmodule : sct_top

// >>> hw/sct_defines.svh
// register indices, field positions, reset values and timing counts
`ifndef SCT_DEFINES_SVH
`define SCT_DEFINES_SVH

// ------------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define SCT_IDX_OSC1_CTL      7'h20
`define SCT_IDX_TONE2_CTL     7'h21
`define SCT_IDX_RING_CTL      7'h22
`define SCT_IDX_METER_CTL     7'h23
`define SCT_IDX_TONE1_OFF_LO  7'h26
`define SCT_IDX_TONE1_OFF_HI  7'h27
`define SCT_IDX_TONE2_ON_LO   7'h28
`define SCT_IDX_TONE2_ON_HI   7'h29
`define SCT_IDX_TONE2_OFF_LO  7'h2a
`define SCT_IDX_TONE2_OFF_HI  7'h2b
`define SCT_IDX_METER_ON_LO   7'h2c
`define SCT_IDX_METER_ON_HI   7'h2d
`define SCT_IDX_METER_OFF_LO  7'h2e
`define SCT_IDX_METER_OFF_HI  7'h2f
`define SCT_IDX_RING_ON_LO    7'h30
`define SCT_IDX_RING_ON_HI    7'h31
`define SCT_IDX_RING_OFF_LO   7'h32
`define SCT_IDX_RING_OFF_HI   7'h33
`define SCT_IDX_CID_BUF       7'h34
`define SCT_IDX_CID_CTL       7'h6c
`define SCT_IDX_TIMER_FIRST   7'h26
`define SCT_IDX_TIMER_LAST    7'h33

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define SCT_BIT_STATUS        7
`define SCT_BIT_RELOAD        6
`define SCT_BIT_ZERO_CROSS    5
`define SCT_BIT_ON_EN         4
`define SCT_BIT_OFF_EN        3
`define SCT_BIT_OSC_EN        2
`define SCT_BIT_CID_EN        6
`define SCT_BIT_CID_DATA      0
`define SCT_RESET_BYTE        8'h00

// ------------------------------------------------------------------
// timebase: one count unit of every cadence timer
// ------------------------------------------------------------------
`define SCT_CLK_PERIOD_NS     50
`define SCT_TICK_NS           125000
`define SCT_TICK_CYCLES       (`SCT_TICK_NS / `SCT_CLK_PERIOD_NS)

`endif

// >>> hw/sct_pkg.sv
// types shared by the cadence timer block
package sct_pkg;

    // cadence phase of one oscillator
    typedef enum logic [1:0] {
        SCT_IDLE,
        SCT_ON,
        SCT_WAIT_ZC,
        SCT_OFF
    } sct_phase_t;

    // settings handed from the register file to one cadence engine
    typedef struct packed {
        logic        oscEnable;
        logic        onTimerEnable;
        logic        offTimerEnable;
        logic        zeroCrossStop;
        logic [15:0] onCount;
        logic [15:0] offCount;
    } sct_cfg_t;

endpackage : sct_pkg

// >>> hw/sct_tick_gen.sv
// timebase divider producing the cadence count unit
`timescale 1ns/1ps
`include "sct_defines.svh"

module sct_tick_gen #(
    parameter int CYCLES = `SCT_TICK_CYCLES
) (
    input  wire logic clock,
    input  wire logic nrst,
    output logic      tick
);
    import sct_pkg::*;

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] divCount;

    // free running divider, one pulse each unit
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            divCount <= '0;
            tick     <= 1'b0;
        end
        else if (divCount == LAST)
        begin
            divCount <= '0;
            tick     <= 1'b1; // R14
        end
        else
        begin
            divCount <= divCount + 1'b1;
            tick     <= 1'b0;
        end
    end

endmodule : sct_tick_gen

// >>> hw/sct_cadence.sv
// one active/inactive cadence engine for an oscillator
`timescale 1ns/1ps

module sct_cadence (
    input  wire logic      clock,
    input  wire logic      nrst,
    input  wire logic      tick,
    input  wire logic      zeroCross,
    input  sct_pkg::sct_cfg_t cfg,
    output logic           active
);
    import sct_pkg::*;

    sct_phase_t  phase;
    logic [15:0] count;
    logic        expire;

    // a period ends on the tick that takes the count to zero
    assign expire = tick && (count <= 16'h0001); // R14

    // phase sequencing and running count
    always_ff @(posedge clock)
    begin
        if (!nrst || !cfg.oscEnable)
        begin
            phase  <= SCT_IDLE;
            count  <= 16'h0000;
            active <= 1'b0;
        end
        else
        begin
            case (phase)
                SCT_IDLE:
                begin
                    phase  <= SCT_ON;
                    count  <= cfg.onCount; // R13
                    active <= 1'b1;
                end
                SCT_ON:
                begin
                    // without the on timer the burst never ends
                    if (cfg.onTimerEnable && expire) // R10
                    begin
                        if (cfg.zeroCrossStop)
                            phase <= SCT_WAIT_ZC; // R11
                        else
                        begin
                            phase  <= SCT_OFF; // R11
                            count  <= cfg.offCount; // R13
                            active <= 1'b0;
                        end
                    end
                    else if (cfg.onTimerEnable && tick)
                        count <= count - 16'h0001; // R14
                end
                SCT_WAIT_ZC:
                begin
                    if (zeroCross) // R11
                    begin
                        phase  <= SCT_OFF;
                        count  <= cfg.offCount;
                        active <= 1'b0;
                    end
                end
                SCT_OFF:
                begin
                    // without the off timer the line stays silent
                    if (cfg.offTimerEnable && expire) // R10
                    begin
                        phase  <= SCT_ON; // R13
                        count  <= cfg.onCount;
                        active <= 1'b1;
                    end
                    else if (cfg.offTimerEnable && tick)
                        count <= count - 16'h0001;
                end
                default:
                begin
                    phase  <= SCT_IDLE;
                    active <= 1'b0;
                end
            endcase
        end
    end

endmodule : sct_cadence

// >>> sim/sct_top_monitor.sv
// checker of bus and cadence behaviour at the timer block ports
`timescale 1ns/1ps
module sct_top_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic              clock,
    input wire logic              nrst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              tone2Active,
    input wire logic              ringActive,
    input wire logic [15:0]       tone1OffCount
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // write of the high byte of the tone 1 off count
    wire wrHi = psel && penable && pready && pwrite && pstrb[0]
        && paddr == 12'h09c;
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    hi_byte_a: assert property (
        wrHi |-> ##2 tone1OffCount[15:8] == $past(pwdata[7:0], 2))
        else $error("tone 1 off high byte not taken");
    cid_upper_a: assert property (
        pready && !pwrite && paddr == 12'h0d0 |-> prdata[7:1] == 7'h00)
        else $error("caller id reserved bits not zero");
    read_upper_a: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    unmapped_err_a: assert property (
        psel && penable && paddr == 12'h0d4 |-> pslverr)
        else $error("unmapped access not refused");
    ring_gap_a: assert property (
        $fell(ringActive) |=> !ringActive [*3])
        else $error("ring silence shorter than one tick");
    cover property ($rose(ringActive));
    cover property ($fell(tone2Active));
    cover property (pslverr);
endmodule : sct_top_monitor

// >>> sim/tb.sv
// self-checking bench for the cadence timer block
`timescale 1ns/1ps
module tb;
    import sct_pkg::*;
    localparam int TK = 4; // short tick keeps cadence runs brief
    logic        clock = 0;
    logic        nrst = 0;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic        tone2ZeroCross = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er, callerIdBitOut;
    logic        tone2Active, meterActive, ringActive;
    logic [15:0] tone1OffCount;
    logic [7:0]  mdl [0:127];
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          c, on, off;
    int          ctl [3] = '{'h21, 'h23, 'h22};
    wire  [2:0]  act = {ringActive, meterActive, tone2Active};
    always #25 clock = ~clock;
    // zero-cross input toggles freely; ignored while the option is off
    always @(posedge clock) tone2ZeroCross <= 1'($urandom);
    sct_top #(.TICK_CYCLES(TK)) u_dut (.*);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one apb transfer; request held until ready is sampled high
    task automatic apb(bit w, int ix, logic [31:0] d);
        int k = 0;
        @(posedge clock);
        psel <= 1;
        pwrite <= w;
        paddr <= 12'(ix * 4);
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (k == 50)
        begin
            n_mismatch++;
            final_report();
        end
    endtask : apb
    // cycles spent at one level of an oscillator's active flag
    task automatic meas(int s, bit lv);
        c = 0;
        while (act[s] === lv && c < 999)
        begin
            @(posedge clock);
            c++;
        end
        if (c == 999)
        begin
            n_mismatch++;
            final_report();
        end
    endtask : meas
    initial
    begin
        void'($urandom(32'ha35c));
        repeat (10) @(posedge clock);
        nrst <= 1;
        for (int i = 'h26; i <= 'h34; i++)
        begin
            apb(0, i, 0);
            chk("reset byte", rd, 0);
        end
        chk("tone1 off", tone1OffCount, 0);
        $display("reset test done");
        for (int i = 'h26; i <= 'h33; i++)
        begin
            mdl[i] = 8'($urandom);
            apb(1, i, $urandom * 256 + mdl[i]);
        end
        for (int i = 'h26; i <= 'h33; i++)
        begin
            apb(0, i, 0);
            chk("timer byte", rd, {24'h0, mdl[i]});
        end
        chk("tone1 off", tone1OffCount, {mdl['h27], mdl['h26]});
        $display("register test done");
        apb(1, 'h34, 32'hff);
        apb(0, 'h34, 0);
        chk("cid buffer", rd, 1);
        apb(1, 'h20, 32'h40);
        apb(1, 'h6c, 32'h40);
        repeat (2) @(posedge clock);
        chk("cid bit", callerIdBitOut, 1);
        apb(1, 'h34, 0);
        repeat (2) @(posedge clock);
        chk("cid bit", callerIdBitOut, 0);
        apb(0, 'h35, 0);
        chk("unmapped err", er, 1);
        chk("unmapped data", rd, 0);
        $display("caller id and unmapped tests done");
        for (int s = 0; s < 3; s++)
        begin
            on = 1 + $urandom % 4;
            off = 1 + $urandom % 4;
            apb(1, 'h28 + 4 * s, on);
            apb(1, 'h29 + 4 * s, 0);
            apb(1, 'h2a + 4 * s, off);
            apb(1, 'h2b + 4 * s, 0);
            apb(1, ctl[s], 32'h1c);
            meas(s, 0);
            meas(s, 1);
            meas(s, 0);
            chk("off ticks", c, off * TK);
            apb(0, ctl[s], 0);
            chk("status on", rd[7], 1);
            meas(s, 1);
            meas(s, 0);
            meas(s, 1);
            chk("on ticks", c, on * TK);
            apb(1, ctl[s], 0);
            apb(0, ctl[s], 0);
            chk("status off", {act[s], rd[7]}, 0);
            $display("cadence test %0d done", s);
        end
        final_report();
    end
endmodule : tb
bind sct_top sct_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
